// ### design/ccw_bank.sv
// Notes on behaviour
// - Zero advance: DAC load one SCLK before sync
// - Advance field moves load by frame/32 steps
// - Eight 8-bit registers, all reset to zero
// - Bit 15 flags control versus data word
// - Bit 14 low, address zero: write register
// - Bit 14 high: read register, send word
// - Nonzero device address: decrement and forward
// - Bits 10..8 select target register
// - Bits 7..0 carry register data when ours
// - Mode bit 0: program or data mode
// - Mode bit 1 enables mixed mode
// - Bits 2,3 enable digital, serial loopback
// - Bits 6..4 hold cascade device count
// - Writing bit 7 starts software reset
// - Clock register holds three divider codes
// - Clock register bit 7 enables echo
// - Power bit 0 is global power-up
// - Power bits 1..5 per-section power-up
// - Bit 6 reference output; bit 7 reserved
// - Gain register holds input, output gain codes
// - Gain bit 3 modulator reset, bit 7 mute
// - Serial clock is INTERNAL_DIVIDED_MASTER_CLOCK over 8,4,2,1
// - Master divider 1..5, other codes one
// - Frame is INTERNAL_DIVIDED_MASTER_CLOCK over 2048..256
// - Registers update on serial clock fall
`default_nettype none
module ccw_bank (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic CE,
   input wire logic SERIAL_DATA_IN,
   input wire logic INPUT_FRAME_SYNC,
   input wire logic [15:0] ADC_SAMPLE,
   output logic SERIAL_CLOCK,
   output logic SERIAL_DATA_OUT,
   output logic ADC_OUTPUT_FRAME_SYNC,
   output logic DAC_LOAD,
   output logic [15:0] DAC_WORD,
   output logic DAC_WORD_VALID,
   output logic OPERATING_MODE_SELECT,
   output logic MIXED_MODE_ENABLE,
   output logic DIGITAL_LOOPBACK_ENABLE,
   output logic SERIAL_PORT_LOOPBACK_ENABLE,
   output logic [2:0] CASCADE_COUNT,
   output logic [1:0] SAMPLE_RATE_CODE,
   output logic [1:0] BIT_CLOCK_DIVIDER,
   output logic [2:0] MASTER_DIVIDER,
   output logic CONTROL_ECHO_ENABLE,
   output logic GLOBAL_POWER_UP,
   output logic ANALOG_TAP_POWER,
   output logic INPUT_AMP_POWER,
   output logic ADC_POWER,
   output logic DAC_POWER,
   output logic REFERENCE_POWER,
   output logic REFERENCE_OUTPUT_ENABLE,
   output logic [2:0] INPUT_GAIN_CODE,
   output logic ADC_MODULATOR_RESET,
   output logic [2:0] OUTPUT_GAIN_CODE,
   output logic OUTPUT_MUTE,
   output logic [4:0] DAC_ADVANCE,
   output logic INTERPOLATOR_BYPASS,
   output logic DIGITAL_TAP_ENABLE,
   output logic [7:0] ANALOG_TAP_CONTROL,
   output logic [15:0] DIGITAL_TAP_COEFF,
   output logic SOFT_RESET_BUSY
);
   typedef struct packed {
      logic [7:0][7:0] regs;
      logic [2:0] mdiv_cnt;
      logic [3:0] sdiv_cnt;
      logic sclk;
      logic [11:0] frame_cnt;
      logic [3:0] srst_cnt;
      logic [15:0] tx_sr;
      logic [4:0] tx_cnt;
      logic sdo;
      logic adc_output_frame_sync;
      logic tx_pend;
      logic [15:0] tx_word;
      logic rx_act;
      logic [4:0] rx_cnt;
      logic [15:0] rx_sr;
      logic dac_load;
      logic [15:0] dac_word;
      logic dac_valid;
      logic [2:0] sdi_sync;
      logic [2:0] fs_sync;
      logic sdi_f;
      logic fs_f;
      logic busy;
   } ccw_state_s;

   ccw_state_s st;
   ccw_state_s n;
   logic half;
   logic edge_now;
   logic rise;
   logic fall;
   logic [2:0] mdiv;
   logic [3:0] shalf;
   logic [11:0] flen;
   logic [6:0] adv_unit;
   logic [11:0] load_at;
   logic rx_bit;
   logic word_done;
   logic [15:0] rx_word;
   logic [2:0] w_dev;
   logic [2:0] w_ra;
   logic [7:0] w_data;
   logic is_dac;
   logic is_inv;
   logic is_fwd;
   logic is_rd;
   logic is_wr;
   logic is_srst;
   logic [15:0] adc_src;

   always_comb begin
      n = st;
      n.dac_load = 1'b0;
      n.dac_valid = 1'b0;
      // Three-stage synchronisers, change taken when stages two and three agree
      n.sdi_sync = {st.sdi_sync[1:0], SERIAL_DATA_IN};
      n.fs_sync = {st.fs_sync[1:0], INPUT_FRAME_SYNC};
      if (st.sdi_sync[1] == st.sdi_sync[2]) begin
         n.sdi_f = st.sdi_sync[2];
      end
      if (st.fs_sync[1] == st.fs_sync[2]) begin
         n.fs_f = st.fs_sync[2];
      end
      mdiv = ccw_pkg::master_div(st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::MCLK_DIV_LSB +: 3]);
      shalf = ccw_pkg::sclk_halves(st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::SCLK_DIV_LSB +: 2]);
      flen = ccw_pkg::frame_sclks(st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::RATE_LSB +: 2],
                                  st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::SCLK_DIV_LSB +: 2]);
      adv_unit = 7'(flen >> ccw_pkg::ADVANCE_STEPS_LOG2);
      // Advance in steps of one thirty-second frame
      // Product widened first so a large advance cannot wrap
      load_at = 12'(flen - 12'h001 - 12'(st.regs[ccw_pkg::REG_DAC_TIMING][ccw_pkg::ADV_LSB +: 5]) * 12'(adv_unit));
      half = (st.mdiv_cnt == 3'(mdiv - 3'h1));
      edge_now = 1'b0;
      if (half) begin
         n.mdiv_cnt = 3'h0;
      end else begin
         n.mdiv_cnt = 3'(st.mdiv_cnt + 3'h1);
      end
      // Timing stays parked during a soft reset
      if (half && st.srst_cnt != 4'h0) begin
         n.srst_cnt = 4'(st.srst_cnt - 4'h1);
      end else if (half) begin
         if (st.sdiv_cnt == 4'(shalf - 4'h1)) begin
            n.sdiv_cnt = 4'h0;
            edge_now = 1'b1;
            n.sclk = ~st.sclk;
         end else begin
            n.sdiv_cnt = 4'(st.sdiv_cnt + 4'h1);
         end
      end
      rise = edge_now && !st.sclk;
      fall = edge_now && st.sclk;

      // Transmit side on rising serial clock
      adc_src = st.regs[ccw_pkg::REG_MODE][ccw_pkg::DLB_BIT] ? st.dac_word : ADC_SAMPLE;
      if (rise) begin
         n.frame_cnt = (st.frame_cnt == 12'(flen - 12'h001)) ? 12'h000 : 12'(st.frame_cnt + 12'h001);
         // Load point measured back from frame start
         if (st.frame_cnt == load_at) begin
            n.dac_load = 1'b1;
         end
         if (st.frame_cnt == 12'h000) begin
            // Pending answer takes the next output slot
            n.tx_sr = st.tx_pend ? st.tx_word : adc_src;
            n.tx_pend = 1'b0;
            n.sdo = st.tx_pend ? st.tx_word[15] : adc_src[15];
            n.adc_output_frame_sync = 1'b1;
            n.tx_cnt = ccw_pkg::LAST_BIT;
         end else begin
            n.adc_output_frame_sync = 1'b0;
            if (st.tx_cnt != 5'h00) begin
               n.tx_sr = {st.tx_sr[14:0], 1'b0};
               n.sdo = st.tx_sr[14];
               n.tx_cnt = 5'(st.tx_cnt - 5'h01);
            end else begin
               n.sdo = 1'b0;
            end
         end
      end

      // Serial loopback feeds output back in
      rx_bit = st.regs[ccw_pkg::REG_MODE][ccw_pkg::SLB_BIT] ? st.sdo : st.sdi_f;
      word_done = fall && st.rx_act && st.rx_cnt == ccw_pkg::LAST_BIT;
      rx_word = {st.rx_sr[14:0], rx_bit};
      w_dev = rx_word[ccw_pkg::CW_DEV_LSB +: 3];
      w_ra = rx_word[ccw_pkg::CW_REG_LSB +: 3];
      w_data = rx_word[7:0];
      // Mode bits and control flag decide the word's meaning
      is_dac = word_done && st.regs[ccw_pkg::REG_MODE][ccw_pkg::MODE_DATA_BIT]
               && !(st.regs[ccw_pkg::REG_MODE][ccw_pkg::MIXED_BIT] && rx_word[ccw_pkg::CW_CTRL_BIT]);
      is_inv = word_done && !is_dac && !rx_word[ccw_pkg::CW_CTRL_BIT];
      is_fwd = word_done && !is_dac && !is_inv && w_dev != 3'h0;
      is_rd = word_done && !is_dac && !is_inv && w_dev == 3'h0 && rx_word[ccw_pkg::CW_RW_BIT];
      is_wr = word_done && !is_dac && !is_inv && w_dev == 3'h0 && !rx_word[ccw_pkg::CW_RW_BIT];
      is_srst = is_wr && w_ra == ccw_pkg::REG_MODE && w_data[ccw_pkg::SOFT_RESET_BIT];

      // Receive and register update on falling serial clock
      if (fall) begin
         if (!st.rx_act) begin
            n.rx_act = st.fs_f;
            n.rx_cnt = 5'h00;
         end else begin
            n.rx_sr = rx_word;
            n.rx_cnt = 5'(st.rx_cnt + 5'h01);
            if (word_done) begin
               n.rx_act = 1'b0;
            end
         end
      end
      // Data mode sends words to the DAC; mixed mode keeps control words out
      if (is_dac) begin
         n.dac_word = rx_word;
         n.dac_valid = 1'b1;
      end
      // Decrement address and pass word along
      if (is_fwd) begin
         n.tx_word = rx_word;
         n.tx_word[ccw_pkg::CW_DEV_LSB +: 3] = 3'(w_dev - 3'h1);
         n.tx_pend = 1'b1;
      end
      // Fill data field from selected register
      if (is_rd) begin
         n.tx_word = {rx_word[15:8], st.regs[w_ra]};
         n.tx_pend = 1'b1;
      end
      // Write data field into selected register
      if (is_wr) begin
         // Reserved bits masked so they read zero
         n.regs[w_ra] = w_data & ccw_pkg::write_mask(w_ra);
         // Echo a written word back out
         if (st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::ECHO_BIT]) begin
            n.tx_word = rx_word;
            n.tx_pend = 1'b1;
         end
      end
      // Software reset clears bank and timing
      if (is_srst) begin
         n.regs = {ccw_pkg::NUM_REGS{ccw_pkg::REG_RESET_VALUE}};
         n.srst_cnt = ccw_pkg::SOFT_RESET_HALVES;
         n.frame_cnt = 12'h000;
         n.sdiv_cnt = 4'h0;
         n.sclk = 1'b0;
         n.tx_pend = 1'b0;
         n.tx_cnt = 5'h00;
         n.sdo = 1'b0;
         n.adc_output_frame_sync = 1'b0;
      end
      // Busy flag registered so the output comes from a flop
      n.busy = (n.srst_cnt != 4'h0);
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st <= '0;
      end else if (CE) begin
         st <= n;
      end
   end

   assign SERIAL_CLOCK = st.sclk;
   assign SERIAL_DATA_OUT = st.sdo;
   assign ADC_OUTPUT_FRAME_SYNC = st.adc_output_frame_sync;
   assign DAC_LOAD = st.dac_load;
   assign DAC_WORD = st.dac_word;
   assign DAC_WORD_VALID = st.dac_valid;
   assign SOFT_RESET_BUSY = st.busy;
   assign OPERATING_MODE_SELECT = st.regs[ccw_pkg::REG_MODE][ccw_pkg::MODE_DATA_BIT];
   assign MIXED_MODE_ENABLE = st.regs[ccw_pkg::REG_MODE][ccw_pkg::MIXED_BIT];
   assign DIGITAL_LOOPBACK_ENABLE = st.regs[ccw_pkg::REG_MODE][ccw_pkg::DLB_BIT];
   assign SERIAL_PORT_LOOPBACK_ENABLE = st.regs[ccw_pkg::REG_MODE][ccw_pkg::SLB_BIT];
   assign CASCADE_COUNT = st.regs[ccw_pkg::REG_MODE][ccw_pkg::COUNT_LSB +: 3];
   assign SAMPLE_RATE_CODE = st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::RATE_LSB +: 2];
   assign BIT_CLOCK_DIVIDER = st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::SCLK_DIV_LSB +: 2];
   assign MASTER_DIVIDER = st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::MCLK_DIV_LSB +: 3];
   assign CONTROL_ECHO_ENABLE = st.regs[ccw_pkg::REG_CLOCK][ccw_pkg::ECHO_BIT];
   assign GLOBAL_POWER_UP = st.regs[ccw_pkg::REG_POWER][0];
   assign ANALOG_TAP_POWER = st.regs[ccw_pkg::REG_POWER][1];
   assign INPUT_AMP_POWER = st.regs[ccw_pkg::REG_POWER][2];
   assign ADC_POWER = st.regs[ccw_pkg::REG_POWER][3];
   assign DAC_POWER = st.regs[ccw_pkg::REG_POWER][4];
   assign REFERENCE_POWER = st.regs[ccw_pkg::REG_POWER][5];
   assign REFERENCE_OUTPUT_ENABLE = st.regs[ccw_pkg::REG_POWER][6];
   assign INPUT_GAIN_CODE = st.regs[ccw_pkg::REG_GAIN][ccw_pkg::IN_GAIN_LSB +: 3];
   assign OUTPUT_GAIN_CODE = st.regs[ccw_pkg::REG_GAIN][ccw_pkg::OUT_GAIN_LSB +: 3];
   assign ADC_MODULATOR_RESET = st.regs[ccw_pkg::REG_GAIN][ccw_pkg::MOD_RESET_BIT];
   assign OUTPUT_MUTE = st.regs[ccw_pkg::REG_GAIN][ccw_pkg::MUTE_BIT];
   // Advance not interlocked with DAC power; host keeps it still
   assign DAC_ADVANCE = st.regs[ccw_pkg::REG_DAC_TIMING][ccw_pkg::ADV_LSB +: 5];
   assign INTERPOLATOR_BYPASS = st.regs[ccw_pkg::REG_DAC_TIMING][ccw_pkg::BYPASS_BIT];
   assign DIGITAL_TAP_ENABLE = st.regs[ccw_pkg::REG_DAC_TIMING][ccw_pkg::DTAP_EN_BIT];
   assign ANALOG_TAP_CONTROL = st.regs[ccw_pkg::REG_ANALOG_TAP];
   assign DIGITAL_TAP_COEFF = {st.regs[ccw_pkg::REG_TAP_HIGH], st.regs[ccw_pkg::REG_TAP_LOW]};

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   load_position_a: assert property (st.dac_load |-> $past(st.frame_cnt) == $past(load_at))
      else $error("DAC load at wrong frame position");
   dac_pulse_a: assert property ((DAC_LOAD && CE) |=> !DAC_LOAD)
      else $error("DAC load longer than one cycle");
   advance_zero_a: assert property ((st.dac_load && DAC_ADVANCE == 5'h00) |-> st.frame_cnt == 12'h000)
      else $error("Zero advance load not in last serial clock");
   sync_start_a: assert property ($rose(ADC_OUTPUT_FRAME_SYNC) |-> st.frame_cnt == 12'h001)
      else $error("Frame sync not at frame start");
   reserved_zero_a: assert property (!st.regs[ccw_pkg::REG_POWER][7] && !st.regs[ccw_pkg::REG_DAC_TIMING][7])
      else $error("Reserved register bit set");
   reg_write_a: assert property ((CE && is_wr && !is_srst) |=> st.regs[$past(w_ra)] == ($past(w_data) & ccw_pkg::write_mask($past(w_ra))))
      else $error("Register write lost");
   invalid_word_a: assert property ((CE && is_inv) |=> st.regs == $past(st.regs) && !$changed(st.tx_word))
      else $error("Invalid word changed state");
   forward_dec_a: assert property ((CE && is_fwd) |=> st.tx_pend && st.tx_word[13:11] == 3'($past(w_dev) - 3'h1))
      else $error("Forwarded address not decremented");
   read_fill_a: assert property ((CE && is_rd) |=> st.tx_pend && st.tx_word[7:0] == $past(st.regs[w_ra]))
      else $error("Read data not filled in");
   echo_queue_a: assert property ((CE && is_wr && !is_srst && CONTROL_ECHO_ENABLE) |=> st.tx_pend && st.tx_word == $past(rx_word))
      else $error("Echo word not queued");
   soft_reset_a: assert property ((CE && is_srst) |=> st.regs == '0 ##1 SOFT_RESET_BUSY)
      else $error("Soft reset did not clear bank");
   write_on_fall_a: assert property ($changed(st.regs) |-> $past(fall))
      else $error("Register changed off falling edge");
   data_word_a: assert property (DAC_WORD_VALID |-> OPERATING_MODE_SELECT)
      else $error("DAC word taken in program mode");
   dac_word_a: assert property ((CE && is_dac) |=> DAC_WORD_VALID && DAC_WORD == $past(rx_word))
      else $error("Data word not passed to DAC");
   loop_source_a: assert property ((CE && rise && st.frame_cnt == 12'h000 && !st.tx_pend && DIGITAL_LOOPBACK_ENABLE) |=> st.tx_sr == $past(st.dac_word))
      else $error("Loopback frame not from DAC word");

   forward_c: cover property (CE && is_fwd);
   read_c: cover property (CE && is_rd);
   advance_c: cover property (st.dac_load && DAC_ADVANCE != 5'h00);
   soft_reset_c: cover property (CE && is_srst);
endmodule
`default_nettype wire

// ### design/ccw_pkg.sv
`default_nettype none
package ccw_pkg;
   // Register addresses
   localparam logic [2:0] REG_MODE = 3'h0;
   localparam logic [2:0] REG_CLOCK = 3'h1;
   localparam logic [2:0] REG_POWER = 3'h2;
   localparam logic [2:0] REG_GAIN = 3'h3;
   localparam logic [2:0] REG_DAC_TIMING = 3'h4;
   localparam logic [2:0] REG_ANALOG_TAP = 3'h5;
   localparam logic [2:0] REG_TAP_LOW = 3'h6;
   localparam logic [2:0] REG_TAP_HIGH = 3'h7;
   localparam int NUM_REGS = 8;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // Reserved bit 7 of power and DAC timing registers
   localparam logic [7:0] RESERVED_TOP_MASK = 8'h7F;
   localparam logic [7:0] FULL_MASK = 8'hFF;
   // Control word layout
   localparam int WORD_BITS = 16;
   localparam int CW_CTRL_BIT = 15;
   localparam int CW_RW_BIT = 14;
   localparam int CW_DEV_LSB = 11;
   localparam int CW_REG_LSB = 8;
   // Mode register fields
   localparam int MODE_DATA_BIT = 0;
   localparam int MIXED_BIT = 1;
   localparam int DLB_BIT = 2;
   localparam int SLB_BIT = 3;
   localparam int COUNT_LSB = 4;
   localparam int SOFT_RESET_BIT = 7;
   // Clock register fields
   localparam int RATE_LSB = 0;
   localparam int SCLK_DIV_LSB = 2;
   localparam int MCLK_DIV_LSB = 4;
   localparam int ECHO_BIT = 7;
   // Gain register fields
   localparam int IN_GAIN_LSB = 0;
   localparam int MOD_RESET_BIT = 3;
   localparam int OUT_GAIN_LSB = 4;
   localparam int MUTE_BIT = 7;
   // DAC timing register fields
   localparam int ADV_LSB = 0;
   localparam int BYPASS_BIT = 5;
   localparam int DTAP_EN_BIT = 6;
   localparam int ADVANCE_STEPS_LOG2 = 5;
   // Serial clocks per frame at rate code 0 and sclk code 0
   localparam logic [11:0] FRAME_BASE_SCLKS = 12'h100;
   localparam logic [3:0] SCLK_HALF_BASE = 4'h8;
   localparam logic [2:0] MCLK_DIV_MAX_CODE = 3'h4;
   // Soft reset lasts four INTERNAL_DIVIDED_MASTER_CLOCK cycles, counted in INTERNAL_DIVIDED_MASTER_CLOCK halves
   localparam logic [3:0] SOFT_RESET_HALVES = 4'h8;
   localparam logic [4:0] LAST_BIT = 5'h0F;

   function automatic logic [2:0] master_div(input logic [2:0] code);
      master_div = (code <= MCLK_DIV_MAX_CODE) ? 3'(code + 3'h1) : 3'h1;
   endfunction

   function automatic logic [3:0] sclk_halves(input logic [1:0] code);
      sclk_halves = SCLK_HALF_BASE >> code;
   endfunction

   function automatic logic [11:0] frame_sclks(input logic [1:0] rate, input logic [1:0] sc);
      frame_sclks = (FRAME_BASE_SCLKS << sc) >> rate;
   endfunction

   function automatic logic [7:0] write_mask(input logic [2:0] ra);
      write_mask = (ra == REG_POWER || ra == REG_DAC_TIMING) ? RESERVED_TOP_MASK : FULL_MASK;
   endfunction
endpackage
`default_nettype wire

// ### test/ccw_host_model.sv
`default_nettype none
module ccw_host_model (
   input wire logic serial_clock,
   input wire logic serial_data_out,
   input wire logic frame_sync_out,
   output logic serial_data_in,
   output logic frame_sync_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] cap_word;
   logic [15:0] cap_shift;
   int cap_count;
   int cap_bits;
   initial begin
      serial_data_in = 1'b0;
      frame_sync_in = 1'b0;
      cap_word = 16'h0000;
      cap_shift = 16'h0000;
      cap_count = 0;
      cap_bits = 0;
   end
   always @(negedge serial_clock) begin
      if (cap_bits > 0 || frame_sync_out) begin
         cap_shift = {cap_shift[14:0], serial_data_out};
         cap_bits++;
         if (cap_bits == 16) begin
            cap_word = cap_shift;
            cap_count++;
            cap_bits = 0;
         end
      end
   end
   // word sent just after a frame start
   task automatic send_word(input logic [15:0] w);
      int i;
      @(posedge frame_sync_out);
      @(posedge serial_clock);
      frame_sync_in <= 1'b1;
      for (i = 15; i >= 0; i--) begin
         @(posedge serial_clock);
         frame_sync_in <= 1'b0;
         serial_data_in <= w[i];
      end
      @(posedge serial_clock);
      // Released line shows the inverse, not a stale bit
      serial_data_in <= ~w[0];
      @(negedge serial_clock);
   endtask
endmodule
`default_nettype wire

// ### test/codec_control_word_register_bank_tb_top.sv
`default_nettype none
module codec_control_word_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, reset, sdi, fsi, sclk, sdo, fso, dac_load, dac_valid;
   logic [15:0] adc_sample, dac_word, tap_coeff;
   logic mode_sel, mixed, digital_loopback_enable, serial_port_loopback_enable, echo, pu, pu_tap, pu_ia, pu_adc, pu_dac, pu_ref, ref_out;
   logic mod_rst, mute, bypass, dtap, busy, busy_seen;
   logic [2:0] count, mdiv, in_gain, out_gain;
   logic [1:0] rate, sdiv;
   logic [4:0] adv;
   logic [7:0] atap;
   logic [63:0] view, shadow;
   int n_errors, cmp_count;
   assign view = {tap_coeff, atap, 1'b0, dtap, bypass, adv, mute, out_gain, mod_rst, in_gain,
                  1'b0, ref_out, pu_ref, pu_dac, pu_adc, pu_ia, pu_tap, pu,
                  echo, mdiv, sdiv, rate, 1'b0, count, serial_port_loopback_enable, digital_loopback_enable, mixed, mode_sel};
   ccw_bank u_dut (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1), .SERIAL_DATA_IN(sdi),
      .INPUT_FRAME_SYNC(fsi), .ADC_SAMPLE(adc_sample), .SERIAL_CLOCK(sclk), .SERIAL_DATA_OUT(sdo),
      .ADC_OUTPUT_FRAME_SYNC(fso), .DAC_LOAD(dac_load), .DAC_WORD(dac_word), .DAC_WORD_VALID(dac_valid),
      .OPERATING_MODE_SELECT(mode_sel), .MIXED_MODE_ENABLE(mixed), .DIGITAL_LOOPBACK_ENABLE(digital_loopback_enable),
      .SERIAL_PORT_LOOPBACK_ENABLE(serial_port_loopback_enable), .CASCADE_COUNT(count), .SAMPLE_RATE_CODE(rate),
      .BIT_CLOCK_DIVIDER(sdiv), .MASTER_DIVIDER(mdiv), .CONTROL_ECHO_ENABLE(echo), .GLOBAL_POWER_UP(pu),
      .ANALOG_TAP_POWER(pu_tap), .INPUT_AMP_POWER(pu_ia), .ADC_POWER(pu_adc), .DAC_POWER(pu_dac),
      .REFERENCE_POWER(pu_ref), .REFERENCE_OUTPUT_ENABLE(ref_out), .INPUT_GAIN_CODE(in_gain),
      .ADC_MODULATOR_RESET(mod_rst), .OUTPUT_GAIN_CODE(out_gain), .OUTPUT_MUTE(mute), .DAC_ADVANCE(adv),
      .INTERPOLATOR_BYPASS(bypass), .DIGITAL_TAP_ENABLE(dtap), .ANALOG_TAP_CONTROL(atap),
      .DIGITAL_TAP_COEFF(tap_coeff), .SOFT_RESET_BUSY(busy));
   ccw_host_model u_host (.serial_clock(sclk), .serial_data_out(sdo), .frame_sync_out(fso),
      .serial_data_in(sdi), .frame_sync_in(fsi));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (busy) busy_seen <= 1'b1;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic get_frame(output logic [15:0] w);
      int c;
      c = u_host.cap_count;
      wait (u_host.cap_count != c);
      w = u_host.cap_word;
   endtask
   task automatic wr(input logic [2:0] ra, input logic [7:0] d, input logic [7:0] st);
      u_host.send_word({2'b10, 3'h0, ra, d});
      shadow[{ra, 3'b000} +: 8] = st;
      check(view, shadow);
   endtask
   task automatic rd(input logic [2:0] ra);
      logic [15:0] w;
      u_host.send_word({2'b11, 3'h0, ra, 8'h00});
      get_frame(w);
      check(w, {2'b11, 3'h0, ra, shadow[{ra, 3'b000} +: 8]});
   endtask
   task automatic sc_reset_values();
      logic [15:0] w;
      check(view, 64'h0);
      check({dac_word, dac_load, dac_valid, busy}, 19'h0);
      get_frame(w);
      check(w, adc_sample);
   endtask
   task automatic sc_dac_timing(input int steps);
      int n;
      n = 0;
      @(negedge clk_sys iff dac_load);
      while (!fso) begin
         @(negedge clk_sys);
         n++;
      end
      // One serial clock is 16 system clocks; frame of 32 serial clocks
      check(64'(n), 64'(16 * (1 + steps)));
   endtask
   task automatic sc_program();
      wr(3'h1, 8'h83, 8'h83);
      sc_dac_timing(0);
      wr(3'h0, 8'h32, 8'h32);
      // Advance changed while the DAC is still powered down
      wr(3'h4, 8'hE3, 8'h63);
      sc_dac_timing(3);
      wr(3'h2, 8'hFF, 8'h7F);
      wr(3'h3, 8'hA5, 8'hA5);
      wr(3'h6, 8'h34, 8'h34);
      wr(3'h7, 8'h12, 8'h12);
   endtask
   task automatic sc_echo();
      logic [15:0] w;
      wr(3'h5, 8'h5A, 8'h5A);
      get_frame(w);
      check(w, 16'h855A);
   endtask
   task automatic sc_forward_and_invalid();
      logic [15:0] w;
      u_host.send_word(16'h9355);
      get_frame(w);
      check(w, 16'h8B55);
      check(view, shadow);
      u_host.send_word(16'h0377);
      check(view, shadow);
      check(dac_word, 16'h0000);
   endtask
   task automatic sc_soft_reset();
      busy_seen = 1'b0;
      u_host.send_word(16'h8080);
      shadow = 64'h0;
      check(view, shadow);
      check(busy_seen, 1'b1);
   endtask
   task automatic sc_mixed();
      wr(3'h0, 8'h03, 8'h03);
      u_host.send_word(16'h1234);
      check(dac_word, 16'h1234);
      wr(3'h3, 8'h11, 8'h11);
   endtask
   task automatic sc_loop_reset();
      logic [15:0] w;
      wr(3'h0, 8'h0C, 8'h0C);
      get_frame(w);
      check(w, 16'h1234);
      @(negedge clk_sys);
      reset = 1'b1;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      shadow = 64'h0;
      check(view, shadow);
      check(dac_word, 16'h0000);
   endtask
   initial begin
      #2400000;
      n_errors++;
      stop_test();
   end
   initial begin
      n_errors = 0;
      cmp_count = 0;
      shadow = 64'h0;
      busy_seen = 1'b0;
      reset = 1'b1;
      adc_sample = 16'hA5C3;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      sc_reset_values();
      sc_program();
      sc_echo();
      rd(3'h2);
      rd(3'h4);
      rd(3'h7);
      sc_forward_and_invalid();
      sc_soft_reset();
      sc_mixed();
      sc_loop_reset();
      stop_test();
   end
endmodule
`default_nettype wire
